/* logic/epph_defines.svh */
// Timing and encoding constants for the EPP/ECP port handshake engine
`ifndef EPPH_DEFINES_SVH
`define EPPH_DEFINES_SVH

`define EPPH_RETRY_CLKS     5'h10
`define EPPH_EPP_RD_REL     4'h3
`define EPPH_EPP_AW_REL     4'h4
`define EPPH_EPP_FIN        4'h2
`define EPPH_ECP_FWD_REL    4'h2
`define EPPH_ECP_FWD_END    4'h2
`define EPPH_ECP_REV_ASSERT 4'h3
`define EPPH_ECP_REV_REL    4'h2
`define EPPH_FILTER_EXTRA   4'h2
`define EPPH_ACC_DATA_WR    3'h0
`define EPPH_ACC_DATA_RD    3'h1
`define EPPH_ACC_ADDR_WR    3'h2
`define EPPH_ACC_ADDR_RD    3'h3
`define EPPH_ACC_FIFO_WR    3'h4
`define EPPH_ACC_FIFO_RD    3'h5

`endif

/* logic/epph_pkg.sv */
// Types for the EPP/ECP port handshake engine
package epph_pkg;
  typedef logic [2:0] epph_acc_t;
  typedef enum logic [3:0] {
    EPPH_IDLE     = 4'h0,
    EPPH_WAIT_HI  = 4'h1,
    EPPH_DLY_REL  = 4'h2,
    EPPH_WAIT_LO  = 4'h3,
    EPPH_DLY_FIN  = 4'h4,
    EPPH_DONE     = 4'h5,
    EPPH_REV_DLY  = 4'h6,
    EPPH_REV_HI   = 4'h7,
    EPPH_REV_REL  = 4'h8
  } epph_state_t;
endpackage

/* logic/epph_port.sv */
// EPP/ECP parallel port handshake engine behind a PCI target
//
// Behaviour
// - EPP access not done within 16 clocks ends PCI access with retry; cycle continues.
// - Retried EPP access completes with data, no second port cycle started.
// - EPP data read: auto-feed low, released 3 clocks after busy sampled high.
// - EPP address write: select-in released 4 clocks after busy sampled high.
// - Address write: select-in and data driven 2 clocks after busy released.
// - EPP address read: select-in low, released 3 clocks after busy sampled.
// - Filters enabled add 2 clocks to every handshake response.
// - ECP FIFO write completes at once unless FIFO full (retry); outside reverse mode starts forward transfer, strobe low.
// - FIFO write during forward transfer is held for the next transfer.
// - Forward: strobe released 2 after busy high; end 2 after busy low.
// - Reverse transfers only in reverse ECP mode; peripheral starts with ack low.
// - Reverse: auto-feed asserted 3 clocks after ack sampled low.
// - Auto-feed released 2 clocks after ack high; byte stored in FIFO unless it is full or a PCI FIFO write takes that clock.
// - PCI FIFO read returns stored data only, never touches reverse transfer.
// - EPP data write: strobe and data driven 2 clocks after busy released.
`timescale 1ns/1ps
`default_nettype none
`include "epph_defines.svh"

module epph_port #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              acc_req,
  input  wire epph_pkg::epph_acc_t acc_kind,
  input  wire logic [7:0]        acc_wdata,
  output logic                   acc_done,
  output logic                   acc_retry,
  output logic [7:0]             acc_rdata,
  input  wire logic              filter_en,
  input  wire logic              ecp_reverse,
  input  wire logic              busy,
  input  wire logic              ack_n,
  input  wire logic [7:0]        pd_in,
  output logic [7:0]             pd_out,
  output logic                   pd_oe,
  output logic                   stb_n,
  output logic                   afd_n,
  output logic                   slin_n,
  output logic                   fifo_empty,
  output logic                   fifo_full
);
  import epph_pkg::*;

  localparam int AW = $clog2(FIFO_DEPTH);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [3:0] dly(input logic [3:0] base, input logic f);
    dly = f ? 4'(base + `EPPH_FILTER_EXTRA) : base;
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  epph_state_t       st, next_st;
  logic [3:0]        cnt, next_cnt;
  logic [4:0]        acc_cnt, next_acc_cnt;
  logic              pend, next_pend;
  epph_acc_t         pend_kind, next_pend_kind;
  logic              cyc_done, next_cyc_done;
  logic              is_fwd, next_is_fwd;
  logic [7:0]        rbyte, next_rbyte;
  logic [7:0]        next_pd_out;
  logic              next_pd_oe, next_stb_n, next_afd_n, next_slin_n;
  logic              next_acc_done, next_acc_retry;
  logic [7:0]        next_acc_rdata;
  logic [7:0]        fifo [FIFO_DEPTH];
  logic [AW:0]       wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic              fifo_we;
  logic [7:0]        fifo_wd;
  logic [7:0]        next_held, held;

  assign fifo_empty = (wr_ptr == rd_ptr);
  assign fifo_full  = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    next_st        = st;
    next_cnt       = cnt;
    next_acc_cnt   = acc_cnt;
    next_pend      = pend;
    next_pend_kind = pend_kind;
    next_cyc_done  = cyc_done;
    next_is_fwd    = is_fwd;
    next_rbyte     = rbyte;
    next_pd_out    = pd_out;
    next_pd_oe     = pd_oe;
    next_stb_n     = stb_n;
    next_afd_n     = afd_n;
    next_slin_n    = slin_n;
    next_acc_done  = 1'b0;
    next_acc_retry = 1'b0;
    next_acc_rdata = acc_rdata;
    next_wr_ptr    = wr_ptr;
    next_rd_ptr    = rd_ptr;
    next_held      = held;
    fifo_we        = 1'b0;
    fifo_wd        = 8'h00;

    // PCI side: one access at a time, pulse acc_done or acc_retry
    if (acc_req && !acc_done && !acc_retry) begin
      if (acc_kind == `EPPH_ACC_FIFO_WR) begin
        if (!fifo_full) begin
          fifo_we       = 1'b1;
          fifo_wd       = acc_wdata;
          next_wr_ptr   = (AW+1)'(wr_ptr + 1'b1);
          next_acc_done = 1'b1;
        end else begin
          next_acc_retry = 1'b1;
        end
      end else if (acc_kind == `EPPH_ACC_FIFO_RD) begin
        next_acc_done = 1'b1;
        if (!fifo_empty) begin
          next_acc_rdata = fifo[rd_ptr[AW-1:0]];
          next_rd_ptr    = (AW+1)'(rd_ptr + 1'b1);
        end
      end else if (pend && pend_kind == acc_kind) begin
        // retried access finishes from saved result
        if (cyc_done) begin
          next_acc_done  = 1'b1;
          next_acc_rdata = rbyte;
          next_pend      = 1'b0;
          next_cyc_done  = 1'b0;
          next_acc_cnt   = 5'h00;
        end else if (acc_cnt == `EPPH_RETRY_CLKS) begin
          next_acc_retry = 1'b1;
          next_acc_cnt   = 5'h00;
        end else begin
          next_acc_cnt = 5'(acc_cnt + 1'b1);
        end
      end else if (!pend && st == EPPH_IDLE && !is_fwd) begin
        next_pend      = 1'b1;
        next_pend_kind = acc_kind;
        next_acc_cnt   = 5'h01;
        next_st        = EPPH_WAIT_HI;
        if (acc_kind == `EPPH_ACC_DATA_RD) begin
          next_afd_n = 1'b0;
          next_pd_oe = 1'b0;
        end else if (acc_kind == `EPPH_ACC_ADDR_RD) begin
          next_slin_n = 1'b0;
          next_pd_oe  = 1'b0;
        end else if (acc_kind == `EPPH_ACC_ADDR_WR) begin
          next_slin_n = 1'b0;
          next_pd_out = acc_wdata;
          next_pd_oe  = 1'b1;
        end else begin
          next_afd_n  = 1'b0;
          next_pd_out = acc_wdata;
          next_pd_oe  = 1'b1;
        end
      end else begin
        // port busy: retry after the window
        if (acc_cnt == `EPPH_RETRY_CLKS) begin
          next_acc_retry = 1'b1;
          next_acc_cnt   = 5'h00;
        end else begin
          next_acc_cnt = 5'(acc_cnt + 1'b1);
        end
      end
    end

    // Port side
    case (st)
      EPPH_IDLE: begin
        if (ecp_reverse) begin
          next_pd_oe = 1'b0;
          if (!ack_n) begin
            next_cnt = dly(`EPPH_ECP_REV_ASSERT, filter_en);
            next_st  = EPPH_REV_DLY;
          end
        end else if (!fifo_empty && !pend && !(acc_req && acc_kind != `EPPH_ACC_FIFO_WR
                     && acc_kind != `EPPH_ACC_FIFO_RD)) begin
          next_is_fwd    = 1'b1;
          next_stb_n     = 1'b0;
          next_pd_out    = fifo[rd_ptr[AW-1:0]];
          next_pd_oe     = 1'b1;
          next_rd_ptr    = (AW+1)'(rd_ptr + 1'b1);
          next_st        = EPPH_WAIT_HI;
        end
      end
      EPPH_WAIT_HI: begin
        if (busy) begin
          if (is_fwd)
            next_cnt = dly(`EPPH_ECP_FWD_REL, filter_en);
          else if (pend_kind == `EPPH_ACC_ADDR_WR)
            next_cnt = dly(`EPPH_EPP_AW_REL, filter_en);
          else
            next_cnt = dly(`EPPH_EPP_RD_REL, filter_en);
          next_st = EPPH_DLY_REL;
        end
      end
      EPPH_DLY_REL: begin
        if (cnt == 4'h1) begin
          if (is_fwd) next_stb_n = 1'b1;
          else begin
            next_afd_n  = 1'b1;
            next_slin_n = 1'b1;
          end
          if (!is_fwd && (pend_kind == `EPPH_ACC_DATA_RD || pend_kind == `EPPH_ACC_ADDR_RD))
            next_rbyte = pd_in;
          next_st = EPPH_WAIT_LO;
        end else
          next_cnt = 4'(cnt - 1'b1);
      end
      EPPH_WAIT_LO: begin
        if (!busy) begin
          next_cnt = is_fwd ? dly(`EPPH_ECP_FWD_END, filter_en) : dly(`EPPH_EPP_FIN, filter_en);
          next_st  = EPPH_DLY_FIN;
        end
      end
      EPPH_DLY_FIN: begin
        if (cnt == 4'h1) begin
          if (is_fwd) begin
            next_is_fwd = 1'b0;
            next_st     = EPPH_IDLE;
          end else begin
            if (pend_kind == `EPPH_ACC_ADDR_WR) begin
              next_slin_n = 1'b0;
              next_pd_oe  = 1'b1;
            end
            if (pend_kind == `EPPH_ACC_DATA_WR) begin
              next_stb_n = 1'b0;
              next_pd_oe = 1'b1;
            end
            // byte kept for the retried read
            next_cyc_done = 1'b1;
            next_st       = EPPH_DONE;
          end
        end else
          next_cnt = 4'(cnt - 1'b1);
      end
      EPPH_DONE: begin
        // One-clock completion strobe, so it never reads as a new cycle
        next_stb_n  = 1'b1;
        next_slin_n = 1'b1;
        next_st     = EPPH_IDLE;
      end
      EPPH_REV_DLY: begin
        if (cnt == 4'h1) begin
          next_afd_n = 1'b0;
          next_held  = pd_in;
          next_st    = EPPH_REV_HI;
        end else
          next_cnt = 4'(cnt - 1'b1);
      end
      EPPH_REV_HI: begin
        if (ack_n) begin
          next_cnt = dly(`EPPH_ECP_REV_REL, filter_en);
          next_st  = EPPH_REV_REL;
        end
      end
      EPPH_REV_REL: begin
        if (cnt == 4'h1) begin
          next_afd_n = 1'b1;
          if (!fifo_full && !fifo_we) begin
            fifo_we     = 1'b1;
            fifo_wd     = held;
            next_wr_ptr = (AW+1)'(wr_ptr + 1'b1);
          end
          next_st = EPPH_IDLE;
        end else
          next_cnt = 4'(cnt - 1'b1);
      end
      default: next_st = EPPH_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (fifo_we) fifo[wr_ptr[AW-1:0]] <= fifo_wd;
    if (sys_rst) begin
      st <= EPPH_IDLE; cnt <= 4'h0; acc_cnt <= 5'h00;
      pend <= 1'b0; pend_kind <= 3'h0; cyc_done <= 1'b0; is_fwd <= 1'b0;
      rbyte <= 8'h00; pd_out <= 8'h00; pd_oe <= 1'b0;
      stb_n <= 1'b1; afd_n <= 1'b1; slin_n <= 1'b1;
      acc_done <= 1'b0; acc_retry <= 1'b0; acc_rdata <= 8'h00;
      wr_ptr <= '0; rd_ptr <= '0; held <= 8'h00;
    end else begin
      st <= next_st; cnt <= next_cnt; acc_cnt <= next_acc_cnt;
      pend <= next_pend; pend_kind <= next_pend_kind; cyc_done <= next_cyc_done;
      is_fwd <= next_is_fwd; rbyte <= next_rbyte; pd_out <= next_pd_out;
      pd_oe <= next_pd_oe; stb_n <= next_stb_n; afd_n <= next_afd_n;
      slin_n <= next_slin_n; acc_done <= next_acc_done; acc_retry <= next_acc_retry;
      acc_rdata <= next_acc_rdata; wr_ptr <= next_wr_ptr; rd_ptr <= next_rd_ptr;
      held <= next_held;
    end
  end

endmodule
`default_nettype wire

/* verification/epph_peer.sv */
// Behavioural parallel peripheral facing the port engine
`timescale 1ns/1ps
`default_nettype none
module epph_peer (
  input  wire logic       mclk,
  input  wire logic       stb_n,
  input  wire logic       afd_n,
  input  wire logic       slin_n,
  input  wire logic       rev_go,
  input  wire logic [7:0] rev_byte,
  input  wire logic [3:0] hold,
  output logic            busy,
  output logic            ack_n,
  output logic [7:0]      pd_in
);
  int w;
  initial begin
    busy = 1'b0;
    ack_n = 1'b1;
    pd_in = 8'h00;
    forever begin
      @(posedge mclk);
      w = 0;
      if (rev_go) begin
        pd_in <= rev_byte;
        ack_n <= 1'b0;
        do begin
          @(posedge mclk);
          w++;
        end while (afd_n !== 1'b0 && w < 12);
        repeat (2) @(posedge mclk);
        ack_n <= 1'b1;
        do begin
          @(posedge mclk);
          w++;
        end while (afd_n !== 1'b1 && w < 24);
        // Released lines must not keep the old byte
        pd_in <= ~rev_byte;
      end else if (!(stb_n && afd_n && slin_n)) begin
        repeat (2) @(posedge mclk);
        // busy answers a held strobe
        // One-clock completion strobes are not requests
        if (!(stb_n && afd_n && slin_n)) begin
          busy <= 1'b1;
          pd_in <= rev_byte;
          repeat (hold) @(posedge mclk);
          busy <= 1'b0;
          pd_in <= ~rev_byte;
          do begin
            @(posedge mclk);
            w++;
          end while (!(stb_n && afd_n && slin_n) && w < 12);
        end
      end
    end
  end
endmodule
`default_nettype wire

/* verification/epph_port_sva.sv */
// Handshake timing checks on the port engine pins
`timescale 1ns/1ps
`default_nettype none
`include "epph_defines.svh"
module epph_port_sva (
  input wire logic                 mclk,
  input wire logic                 sys_rst,
  input wire logic                 acc_req,
  input wire epph_pkg::epph_acc_t  acc_kind,
  input wire logic                 acc_done,
  input wire logic                 acc_retry,
  input wire logic                 filter_en,
  input wire logic                 ecp_reverse,
  input wire logic                 busy,
  input wire logic                 ack_n,
  input wire logic                 pd_oe,
  input wire logic                 stb_n,
  input wire logic                 afd_n,
  input wire logic                 slin_n,
  input wire logic                 fifo_full
);
  import epph_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Outputs change N edges after the sampling edge, so they are seen one edge later
  sequence s_afd3; !afd_n [*4] ##1 afd_n; endsequence
  sequence s_afd5; !afd_n [*6] ##1 afd_n; endsequence
  sequence s_rev_on; afd_n [*4] ##1 !afd_n; endsequence
  a_afd_release: assert property ($rose(busy) && !afd_n && !filter_en |-> s_afd3) // release
    else $error("auto-feed release off");
  a_afd_filtered: assert property ($rose(busy) && !afd_n && filter_en |-> s_afd5) // filtered
    else $error("filtered release off");
  a_aw_release: assert property ($rose(busy) && !slin_n && !filter_en && acc_kind == `EPPH_ACC_ADDR_WR // release
    |-> !slin_n [*5] ##1 slin_n) else $error("select-in write release off");
  a_aw_finish: assert property ($fell(busy) && !filter_en && acc_kind == `EPPH_ACC_ADDR_WR // finish
    |-> ##3 (!slin_n && pd_oe)) else $error("address write finish off");
  a_ar_release: assert property ($rose(busy) && !slin_n && !filter_en && acc_kind == `EPPH_ACC_ADDR_RD // release
    |-> !slin_n [*4] ##1 slin_n) else $error("select-in read release off");
  a_dw_finish: assert property ($fell(busy) && !filter_en && acc_kind == `EPPH_ACC_DATA_WR // finish
    |-> ##3 (!stb_n && pd_oe)) else $error("data write finish off");
  a_fwd_release: assert property ($rose(busy) && !stb_n && !filter_en |-> !stb_n [*3] ##1 stb_n) // release
    else $error("forward strobe release off");
  a_rev_assert: assert property ($fell(ack_n) && ecp_reverse && !filter_en |-> s_rev_on) // assert
    else $error("reverse auto-feed late");
  a_rev_release: assert property ($rose(ack_n) && ecp_reverse && !afd_n && !filter_en // release
    |-> !afd_n [*3] ##1 afd_n) else $error("reverse release off");
  a_fifo_wr_done: assert property (acc_req && acc_kind == `EPPH_ACC_FIFO_WR && !fifo_full // done
    && !acc_done && !acc_retry |=> acc_done) else $error("fifo write not done");
  a_epp_answer: assert property ($rose(acc_req) && acc_kind <= `EPPH_ACC_ADDR_RD // bound
    |-> ##[1:18] (acc_done || acc_retry)) else $error("epp access unanswered");
endmodule
bind epph_port epph_port_sva i_sva (.mclk, .sys_rst, .acc_req, .acc_kind, .acc_done, .acc_retry,
  .filter_en, .ecp_reverse, .busy, .ack_n, .pd_oe, .stb_n, .afd_n, .slin_n, .fifo_full);
`default_nettype wire

/* verification/epph_port_tb.sv */
// Self-checking bench for the port handshake engine
`timescale 1ns/1ps
`default_nettype none
`include "epph_defines.svh"
module epph_port_tb;
  import epph_pkg::*;
  logic       mclk, sys_rst, acc_req, acc_done, acc_retry, filter_en, ecp_reverse, rev_go, stb_q;
  logic       busy, ack_n, pd_oe, stb_n, afd_n, slin_n, fifo_empty, fifo_full;
  epph_acc_t  acc_kind;
  logic [7:0] acc_wdata, acc_rdata, pd_in, pd_out, rev_byte;
  logic [3:0] hold;
  int         n_fail, n_checks, n_busy, n_afd;
  logic [7:0] fwd_q[$];
  epph_port #(.FIFO_DEPTH(16)) i_dut (.mclk, .sys_rst, .acc_req, .acc_kind, .acc_wdata, .acc_done, .acc_retry,
    .acc_rdata, .filter_en, .ecp_reverse, .busy, .ack_n, .pd_in, .pd_out, .pd_oe, .stb_n, .afd_n, .slin_n,
    .fifo_empty, .fifo_full);
  epph_peer i_peer (.mclk, .stb_n, .afd_n, .slin_n, .rev_go, .rev_byte, .hold, .busy, .ack_n, .pd_in);
  always #50 mclk = ~mclk;
  always @(posedge busy) n_busy++;
  always @(negedge afd_n) n_afd++;
  // Byte on the lines when the forward strobe falls
  always @(posedge mclk) begin
    if (stb_q && !stb_n) fwd_q.push_back(pd_out);
    stb_q <= stb_n;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Edge gap first so acc_req never toggles twice in one step
  task acc(input epph_acc_t k, input logic [7:0] d, output int c);
    @(posedge mclk);
    acc_req <= 1'b1;
    acc_kind <= k;
    acc_wdata <= d;
    c = 0;
    do begin
      @(posedge mclk);
      c++;
    end while (acc_done !== 1'b1 && acc_retry !== 1'b1 && c < 40);
    acc_req <= 1'b0;
  endtask
  task t_epp(input epph_acc_t k, input logic [7:0] d, input logic f);
    int c;
    int nb;
    filter_en <= f;
    hold <= 4'he;
    rev_byte <= d;
    nb = n_busy;
    acc(k, d, c);
    chk(acc_retry, 1, "no retry"); // retry
    chk(c >= 15 && c <= 19, 1, "retry timing"); // timing
    acc(k, d, c);
    chk(acc_done, 1, "retried access not done"); // done
    if (k == `EPPH_ACC_DATA_RD || k == `EPPH_ACC_ADDR_RD) chk(acc_rdata, d, "read byte"); // held
    repeat (20) @(posedge mclk);
    chk(n_busy - nb, 1, "port cycle count"); // single
    $display("test epp kind %0d filter %0d done", k, f);
  endtask
  task t_fwd;
    int c;
    int nb;
    filter_en <= 1'b0;
    hold <= 4'h4;
    fwd_q.delete();
    nb = n_busy;
    acc(`EPPH_ACC_FIFO_WR, 8'h3c, c);
    chk(acc_done && c <= 3, 1, "fifo write slow"); // done
    acc(`EPPH_ACC_FIFO_WR, 8'hc3, c);
    chk(acc_done, 1, "second write"); // accepted
    repeat (40) @(posedge mclk);
    chk(n_busy - nb, 2, "forward count"); // count
    chk({16'(fwd_q.size()), fwd_q[0], fwd_q[1]}, {16'h2, 16'h3cc3}, "forward bytes"); // order
    chk(fifo_empty, 1, "fifo not drained"); // drained
    $display("test forward done");
  endtask
  task rev_pulse(input logic m, input logic [7:0] b);
    ecp_reverse <= m;
    rev_byte <= b;
    rev_go <= 1'b1;
    @(posedge mclk);
    rev_go <= 1'b0;
    repeat (40) @(posedge mclk);
  endtask
  task t_rev;
    int c;
    int na;
    na = n_afd;
    rev_pulse(1'b0, 8'h5a);
    chk(fifo_empty, 1, "reverse outside mode"); // mode
    chk(n_afd - na, 0, "auto-feed outside mode"); // mode
    rev_pulse(1'b1, 8'ha5);
    chk(n_afd - na, 1, "no reverse answer"); // answer
    chk(fifo_empty, 0, "byte not stored"); // stored
    acc(`EPPH_ACC_FIFO_RD, 8'h00, c);
    chk({acc_done, acc_rdata}, 9'h1a5, "fifo read"); // data
    repeat (10) @(posedge mclk);
    chk(n_afd - na, 1, "read touched port"); // quiet
    chk(fifo_empty, 1, "fifo not emptied"); // emptied
    ecp_reverse <= 1'b0;
    $display("test reverse done");
  endtask
  // Reverse mode keeps forward transfers off, so the FIFO can be filled
  task t_full;
    int c;
    ecp_reverse <= 1'b1;
    for (int i = 0; i < 16; i++) acc(`EPPH_ACC_FIFO_WR, 8'(i), c);
    chk(fifo_full, 1, "fifo not full"); // depth
    acc(`EPPH_ACC_FIFO_WR, 8'hff, c);
    chk(acc_retry, 1, "write to full fifo"); // refused
    for (int i = 0; i < 16; i++) begin
      acc(`EPPH_ACC_FIFO_RD, 8'h00, c);
      chk({acc_done, acc_rdata}, {1'b1, 8'(i)}, "fifo order"); // data
    end
    chk({fifo_full, fifo_empty}, 2'h1, "fifo flags after drain"); // drained
    ecp_reverse <= 1'b0;
    $display("test fifo full done");
  endtask
  initial begin
    {mclk, acc_req, filter_en, ecp_reverse, rev_go, stb_q} = 6'h01;
    sys_rst = 1'b1;
    {acc_kind, acc_wdata, rev_byte, hold} = 0;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int k = 0; k < 4; k++) t_epp(epph_acc_t'(k), 8'(8'h61 + k), 1'b0);
    t_epp(`EPPH_ACC_DATA_RD, 8'h96, 1'b1);
    t_fwd();
    t_rev();
    t_full();
    print_verdict();
  end
  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    print_verdict();
  end
endmodule
`default_nettype wire
